// File: twm_pkg.sv
// Purpose: shared constants of the timer waveform block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   every offset is a byte address
`default_nettype none

package twm_pkg;

    // ==========================================================
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_FORCE = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_CMPA  = 8'h0c;
    localparam logic [7:0] ADDR_CMPB  = 8'h10;
    localparam logic [7:0] ADDR_FLAGS = 8'h14;
    localparam logic [7:0] ADDR_PORT  = 8'h18;
    localparam logic [7:0] ADDR_WAVE  = 8'h1c;

    // ==========================================================
    // field positions
    localparam int CTRL_WGM_LSB  = 0;
    localparam int CTRL_COMA_LSB = 4;
    localparam int CTRL_COMB_LSB = 6;
    localparam int FLAG_OVF_BIT  = 0;
    localparam int FLAG_CMP_LSB  = 1;
    localparam int PORT_DATA_LSB = 0;
    localparam int PORT_DIR_LSB  = 4;
    localparam int NUM_CHAN      = 2;

    // ==========================================================
    // waveform generation modes
    localparam logic [2:0] WGM_NORMAL   = 3'h0;
    localparam logic [2:0] WGM_CTC      = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_FAST_OCR = 3'h7;

    // ==========================================================
    // compare output modes
    localparam logic [1:0] COM_NONE   = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // ==========================================================
    // counter limits and reset values
    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [2:0] RST_WGM    = 3'h0;
    localparam logic [1:0] RST_COM    = 2'h0;
    localparam logic [7:0] RST_COUNT  = 8'h00;
    localparam logic [7:0] RST_CMP    = 8'h00;
    localparam logic [1:0] RST_BITS   = 2'h0;

endpackage

`default_nettype wire

// File: twm_timer_wave.sv
// Purpose: 8-bit timer counter with compare output waveform unit
// Assumes: timerTick is a one-cycle enable from a prescaler on clk_sys
// Notes:   zero-wait APB slave; phase correct and reserved modes count
//          as normal mode
`default_nettype none

// How it works
// - nonzero compare mode puts waveform on pin
// - direction bit still gates pin drive
// - override ignores waveform generation mode
// - compare mode zero holds waveform state
// - new compare mode acts at next match
// - force strobe applies action in non-PWM
// - only generation mode chooses counting sequence
// - normal mode counts up, wraps ff to 00
// - normal overflow flag as counter becomes zero
// - counter only sets overflow, software clears
// - clear-on-match mode clears on compare A
// - unbuffered compare A, missed match wraps around
// - clear-on-match sets compare flag A at top
// - toggle mode inverts output A each match
// - clear-on-match overflow on max to zero
// - modes 3 and 7 fast PWM, tops
// - fast PWM counts to top, then clears
// - non-inverting clears at match, sets bottom
// - two non-inverting, three inverting
// - fast PWM overflow flag at top
// - zero gives spike, max gives level
// - fast PWM toggle mode on match
// - compare buffered only in PWM modes
// - match sets compare flag next timer cycle
// - forced compare touches only waveform state
// - waveform state writable before pin enabled
module twm_timer_wave
    import twm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timerTick,
    output logic      [1:0]  pinOut,
    output logic      [1:0]  pinOeN,
    output logic      [7:0]  counterValue,
    output logic             overflowFlag,
    output logic             compareFlagA,
    output logic             compareFlagB
);

    // ==========================================================
    // decode helpers
    function automatic logic isPwm(input logic [2:0] m);
        return (m == WGM_FAST_MAX) || (m == WGM_FAST_OCR);
    endfunction

    function automatic logic compareAction(
        input logic [1:0] com,
        input logic       w
    );
        logic r;
        r = w;
        unique case (com)
            COM_NONE:   r = w;
            COM_TOGGLE: r = ~w;
            COM_CLEAR:  r = 1'b0;
            COM_SET:    r = 1'b1;
        endcase
        return r;
    endfunction

    function automatic logic isMapped(input logic [7:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_FORCE) ||
               (a == ADDR_COUNT) || (a == ADDR_CMPA) ||
               (a == ADDR_CMPB) || (a == ADDR_FLAGS) ||
               (a == ADDR_PORT) || (a == ADDR_WAVE);
    endfunction

    // ==========================================================
    // state
    logic [2:0]       waveGenMode_r;
    logic [2:0]       waveGenMode_nxt;
    logic [1:0][1:0]  compareOutputMode_r;
    logic [1:0][1:0]  compareOutputMode_nxt;
    logic [7:0]       counterValue_r;
    logic [7:0]       counterValue_nxt;
    logic [1:0][7:0]  compareValueChan_r;
    logic [1:0][7:0]  compareValueChan_nxt;
    logic [1:0][7:0]  compareBuf_r;
    logic [1:0][7:0]  compareBuf_nxt;
    logic             overflowFlag_r;
    logic             overflowFlag_nxt;
    logic [1:0]       compareFlagChan_r;
    logic [1:0]       compareFlagChan_nxt;
    logic [1:0]       waveState_r;
    logic [1:0]       waveState_nxt;
    logic [1:0]       portData_r;
    logic [1:0]       portData_nxt;
    logic [1:0]       pinDirectionBit_r;
    logic [1:0]       pinDirectionBit_nxt;
    logic             blockMatch_r;
    logic             blockMatch_nxt;
    logic [31:0]      prdata_r;
    logic [31:0]      prdata_nxt;

    // ==========================================================
    // bus strobes and counter conditions
    logic             busWr;
    logic             ctrlWr;
    logic             forceWr;
    logic             countWr;
    logic             flagsWr;
    logic             portWr;
    logic             waveWr;
    logic [1:0]       cmpWr;
    logic             pwmMode;
    logic [7:0]       topValue;
    logic             atTop;
    logic             topTick;
    logic             matchEn;
    logic [1:0]       matchChan;
    logic [1:0]       forceChan;

    assign busWr   = psel & penable & pwrite;
    assign ctrlWr  = busWr & (paddr == ADDR_CTRL);
    assign forceWr = busWr & (paddr == ADDR_FORCE);
    assign countWr = busWr & (paddr == ADDR_COUNT);
    assign flagsWr = busWr & (paddr == ADDR_FLAGS);
    assign portWr  = busWr & (paddr == ADDR_PORT);
    assign waveWr  = busWr & (paddr == ADDR_WAVE);
    assign cmpWr   = {busWr & (paddr == ADDR_CMPB), busWr & (paddr == ADDR_CMPA)};

    assign pwmMode  = isPwm(waveGenMode_r);
    assign topValue = (waveGenMode_r == WGM_FAST_OCR) ? compareValueChan_r[0]
                                                      : CNT_MAX;
    assign atTop    = (counterValue_r == topValue);
    assign topTick  = timerTick & pwmMode & atTop & ~countWr;

    // a counter write blocks matches for the following timer cycle, and a write
    // in the tick cycle itself wins over any match on the old value
    assign matchEn  = timerTick & ~blockMatch_r & ~countWr;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
            assign matchChan[ch] = matchEn &
                                   (counterValue_r == compareValueChan_r[ch]);
            assign forceChan[ch] = forceWr & pwdata[ch] & ~pwmMode;
            assign pinOut[ch]    = (compareOutputMode_r[ch] != COM_NONE)
                                   ? waveState_r[ch] : portData_r[ch];
            assign pinOeN[ch]    = ~pinDirectionBit_r[ch];
        end
    endgenerate

    // ==========================================================
    // next-state logic
    always_comb begin
        waveGenMode_nxt       = waveGenMode_r;
        compareOutputMode_nxt = compareOutputMode_r;
        counterValue_nxt      = counterValue_r;
        compareValueChan_nxt  = compareValueChan_r;
        compareBuf_nxt        = compareBuf_r;
        overflowFlag_nxt      = overflowFlag_r;
        compareFlagChan_nxt   = compareFlagChan_r;
        waveState_nxt         = waveState_r;
        portData_nxt          = portData_r;
        pinDirectionBit_nxt   = pinDirectionBit_r;
        blockMatch_nxt        = blockMatch_r;
        prdata_nxt            = prdata_r;

        // control fields; mode change acts from the next edge on
        if (ctrlWr) begin
            waveGenMode_nxt          = pwdata[CTRL_WGM_LSB +: 3];
            compareOutputMode_nxt[0] = pwdata[CTRL_COMA_LSB +: 2];
            compareOutputMode_nxt[1] = pwdata[CTRL_COMB_LSB +: 2];
        end

        // counting: chosen by generation mode only
        if (timerTick) begin
            if (pwmMode) begin
                counterValue_nxt = atTop ? CNT_BOTTOM
                                         : counterValue_r + 8'h01;
            end else if (waveGenMode_r == WGM_CTC && matchChan[0]) begin
                counterValue_nxt = CNT_BOTTOM;
            end else begin
                counterValue_nxt = counterValue_r + 8'h01;
            end
            if (pwmMode ? atTop : (counterValue_r == CNT_MAX)) begin
                overflowFlag_nxt = 1'b1;
            end
            blockMatch_nxt = 1'b0;
        end
        if (countWr) begin
            counterValue_nxt = pwdata[7:0];
            blockMatch_nxt   = 1'b1;
        end

        // compare registers: buffer always, active copy per mode
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (cmpWr[i]) begin
                compareBuf_nxt[i] = pwdata[7:0];
            end
            if (!pwmMode) begin
                if (cmpWr[i]) begin
                    compareValueChan_nxt[i] = pwdata[7:0];
                end
            end else if (topTick) begin
                compareValueChan_nxt[i] = compareBuf_nxt[i];
            end
        end

        // waveform state; bottom wins over a match at the same tick
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (pwmMode) begin
                unique case (compareOutputMode_r[i])
                    COM_NONE: begin
                        waveState_nxt[i] = waveState_r[i];
                    end
                    COM_TOGGLE: begin
                        if (matchChan[i]) begin
                            waveState_nxt[i] = ~waveState_r[i];
                        end
                    end
                    COM_CLEAR: begin
                        if (topTick) begin
                            waveState_nxt[i] = 1'b1;
                        end else if (matchChan[i]) begin
                            waveState_nxt[i] = 1'b0;
                        end
                    end
                    COM_SET: begin
                        if (topTick) begin
                            waveState_nxt[i] = 1'b0;
                        end else if (matchChan[i]) begin
                            waveState_nxt[i] = 1'b1;
                        end
                    end
                endcase
            end else if (matchChan[i] || forceChan[i]) begin
                waveState_nxt[i] = compareAction(compareOutputMode_r[i],
                                                 waveState_r[i]);
            end
        end
        if (waveWr) begin
            waveState_nxt = pwdata[1:0];
        end

        // flags: hardware set wins over a software clear
        if (flagsWr) begin
            overflowFlag_nxt    = overflowFlag_nxt & ~pwdata[FLAG_OVF_BIT];
            compareFlagChan_nxt = compareFlagChan_r & ~pwdata[FLAG_CMP_LSB +: 2];
        end
        compareFlagChan_nxt = compareFlagChan_nxt | matchChan;
        if (timerTick && (pwmMode ? atTop : (counterValue_r == CNT_MAX))) begin
            overflowFlag_nxt = 1'b1;
        end

        // port bits
        if (portWr) begin
            portData_nxt        = pwdata[PORT_DATA_LSB +: 2];
            pinDirectionBit_nxt = pwdata[PORT_DIR_LSB +: 2];
        end

        // read data is captured in the setup cycle so it is a flop output
        if (psel && !penable) begin
            unique case (paddr)
                ADDR_CTRL:  prdata_nxt = {24'h000000, compareOutputMode_r[1],
                                          compareOutputMode_r[0], 1'b0, waveGenMode_r};
                ADDR_COUNT: prdata_nxt = {24'h000000, counterValue_r};
                ADDR_CMPA:  prdata_nxt = {24'h000000, compareBuf_r[0]};
                ADDR_CMPB:  prdata_nxt = {24'h000000, compareBuf_r[1]};
                ADDR_FLAGS: prdata_nxt = {29'h00000000, compareFlagChan_r, overflowFlag_r};
                ADDR_PORT:  prdata_nxt = {26'h0000000, pinDirectionBit_r, 2'h0, portData_r};
                ADDR_WAVE:  prdata_nxt = {30'h00000000, waveState_r};
                default:    prdata_nxt = 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            waveGenMode_r       <= RST_WGM;
            compareOutputMode_r <= {RST_COM, RST_COM};
            counterValue_r      <= RST_COUNT;
            compareValueChan_r  <= {RST_CMP, RST_CMP};
            compareBuf_r        <= {RST_CMP, RST_CMP};
            overflowFlag_r      <= 1'b0;
            compareFlagChan_r   <= RST_BITS;
            waveState_r         <= RST_BITS;
            portData_r          <= RST_BITS;
            pinDirectionBit_r   <= RST_BITS;
            blockMatch_r        <= 1'b0;
            prdata_r            <= 32'h00000000;
        end else begin
            waveGenMode_r       <= waveGenMode_nxt;
            compareOutputMode_r <= compareOutputMode_nxt;
            counterValue_r      <= counterValue_nxt;
            compareValueChan_r  <= compareValueChan_nxt;
            compareBuf_r        <= compareBuf_nxt;
            overflowFlag_r      <= overflowFlag_nxt;
            compareFlagChan_r   <= compareFlagChan_nxt;
            waveState_r         <= waveState_nxt;
            portData_r          <= portData_nxt;
            pinDirectionBit_r   <= pinDirectionBit_nxt;
            blockMatch_r        <= blockMatch_nxt;
            prdata_r            <= prdata_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign prdata       = prdata_r;
    assign pready       = 1'b1;
    assign pslverr      = psel & penable & ~isMapped(paddr);
    assign counterValue = counterValue_r;
    assign overflowFlag = overflowFlag_r;
    assign compareFlagA = compareFlagChan_r[0];
    assign compareFlagB = compareFlagChan_r[1];

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_fastTop;
        timerTick && pwmMode && atTop && !countWr;
    endsequence

    sequence s_restart;
        counterValue_r == CNT_BOTTOM && overflowFlag_r;
    endsequence

    pin_override_a: assert property (
        compareOutputMode_r[0] != COM_NONE |-> pinOut[0] == waveState_r[0])
        else $error("pin not driven by waveform state");

    pin_direction_a: assert property (
        !pinDirectionBit_r[1] |-> pinOeN[1])
        else $error("pin driven while direction is input");

    wave_hold_a: assert property (
        compareOutputMode_r[0] == COM_NONE && !waveWr && !ctrlWr
        |=> $stable(waveState_r[0]))
        else $error("waveform changed with compare mode zero");

    normal_wrap_a: assert property (
        timerTick && waveGenMode_r == WGM_NORMAL && counterValue_r == CNT_MAX
        && !countWr |=> s_restart)
        else $error("normal mode did not wrap with overflow");

    ctc_clear_a: assert property (
        waveGenMode_r == WGM_CTC && matchChan[0] && !countWr
        |=> counterValue_r == CNT_BOTTOM && compareFlagA)
        else $error("clear-on-match did not clear and flag");

    fast_top_a: assert property (
        s_fastTop |=> s_restart)
        else $error("fast pwm did not restart at top");

    tick_gate_a: assert property (
        !timerTick && !countWr |=> $stable(counterValue_r))
        else $error("counter moved without timer enable");

    ovf_sticky_a: assert property (
        overflowFlag_r && !(flagsWr && pwdata[FLAG_OVF_BIT])
        |=> overflowFlag_r)
        else $error("overflow flag cleared by counting");

    force_noflag_a: assert property (
        forceWr && !timerTick && !flagsWr
        |=> $stable(compareFlagChan_r) && $stable(counterValue_r))
        else $error("forced compare touched flag or counter");

    cmp_buffer_a: assert property (
        pwmMode && cmpWr[1] && !topTick && !ctrlWr
        |=> $stable(compareValueChan_r[1]))
        else $error("pwm compare value not buffered");

endmodule

`default_nettype wire

// File: twm_load_model.sv
// Purpose: external load hanging on the two waveform pins
// Assumes: each pin has a pull-up on the board
// Notes:   the level follows the driver only while its enable is low
`default_nettype none

module twm_load_model (
    input  wire logic [1:0] pinOut,
    input  wire logic [1:0] pinOeN,
    output logic      [1:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // pin resolution
    // a released pin shows the pull-up, never the last driven value
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pinLevel[i] = pinOeN[i] ? 1'b1 : pinOut[i];
        end
    end
endmodule

`default_nettype wire

// File: test_timer_waveform_output_modes.sv
// Purpose: self-checking bench for the timer waveform block
// Assumes: zero-wait APB slave, timer tick made by the bench
// Notes:   plain counting cases run from a table, odd cases by hand
`default_nettype none

module test_timer_waveform_output_modes
    import twm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cmpa;
        logic [7:0] cnt0;
        logic [1:0] wave0;
        logic [8:0] ticks;
        logic [7:0] cnt;
        logic [2:0] flags;
        logic [1:0] wave;
    } twm_row_t;

    logic        clk_sys, rst, psel, penable, pwrite, timerTick;
    logic [7:0]  paddr, counterValue;
    logic [31:0] pwdata, prdata, rdData;
    logic        pready, pslverr, errSeen;
    logic [1:0]  pinOut, pinOeN, pinLevel;
    logic        overflowFlag, compareFlagA, compareFlagB;
    int          fail_count, n_tests, hi;

    // ==========================================================
    // ordinary cases: setup, tick count, expected state
    twm_row_t rows [7] = '{
        '{8'h00, 8'h10, 8'hfe, 2'h0, 9'd2,   8'h00, 3'h1, 2'h0},
        '{8'h12, 8'h03, 8'h00, 2'h0, 9'd4,   8'h00, 3'h2, 2'h1},
        '{8'h12, 8'h05, 8'h10, 2'h0, 9'd246, 8'h00, 3'h7, 2'h1},
        '{8'h23, 8'h80, 8'hfe, 2'h0, 9'd131, 8'h81, 3'h7, 2'h0},
        '{8'h33, 8'h80, 8'hfe, 2'h0, 9'd131, 8'h81, 3'h7, 2'h1},
        '{8'h17, 8'h04, 8'h00, 2'h0, 9'd5,   8'h00, 3'h3, 2'h1},
        '{8'h02, 8'h03, 8'h00, 2'h1, 9'd4,   8'h00, 3'h2, 2'h1}
    };

    twm_timer_wave u_twm_timer_wave (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timerTick(timerTick),
        .pinOut(pinOut), .pinOeN(pinOeN), .counterValue(counterValue),
        .overflowFlag(overflowFlag), .compareFlagA(compareFlagA),
        .compareFlagB(compareFlagB)
    );

    twm_load_model u_twm_load_model (
        .pinOut(pinOut), .pinOeN(pinOeN), .pinLevel(pinLevel)
    );

    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // ==========================================================
    // shared tasks
    task automatic summarize();
        $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            fail_count++;
            summarize();
        end
        rdData  = prdata;
        errSeen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // flops written at the access edge settle before the caller looks
        @(negedge clk_sys);
    endtask

    // n back-to-back ticks, outputs looked at once they settle
    task automatic ticks(input int n);
        @(posedge clk_sys);
        timerTick <= 1'b1;
        repeat (n) @(posedge clk_sys);
        timerTick <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic prep(input logic [7:0] cmp, input logic [7:0] cnt);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CMPA, {24'h0, cmp});
        apb(1'b1, ADDR_COUNT, {24'h0, cnt});
        apb(1'b1, ADDR_FLAGS, 32'h7);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, timerTick, paddr, pwdata} = '0;
        fail_count = 0;
        n_tests    = 0;
        rst        = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            prep(rows[i].cmpa, rows[i].cnt0);
            apb(1'b1, ADDR_WAVE, {30'h0, rows[i].wave0});
            apb(1'b1, ADDR_CTRL, {24'h0, rows[i].ctrl});
            ticks(int'(rows[i].ticks));
            check(counterValue, rows[i].cnt);
            check({compareFlagB, compareFlagA, overflowFlag}, rows[i].flags);
            apb(1'b0, ADDR_WAVE, 32'h0);
            check(rdData, rows[i].wave);
        end
        // new compare mode waits for the next match
        prep(8'h02, 8'h00);
        apb(1'b1, ADDR_WAVE, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h32);
        apb(1'b0, ADDR_WAVE, 32'h0);
        check(rdData, 32'h0);
        ticks(3);
        apb(1'b0, ADDR_WAVE, 32'h0);
        check(rdData, 32'h1);
        // pin override in every mode, direction still rules
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_WAVE, 32'h0);
        apb(1'b1, ADDR_PORT, 32'h11);
        check(pinLevel, 2'b11);
        check(pinOeN, 2'b10);
        foreach (rows[i]) begin
            apb(1'b1, ADDR_CTRL, {24'h0, rows[i].ctrl[7:4], 1'b0, rows[i].ctrl[2:0]} | 32'h10);
            check(pinLevel[0], 1'b0);
        end
        apb(1'b1, ADDR_PORT, 32'h00);
        apb(1'b1, ADDR_WAVE, 32'h1);
        check(pinOeN, 2'b11);
        apb(1'b0, ADDR_WAVE, 32'h0);
        check(rdData, 32'h1);
        apb(1'b1, ADDR_PORT, 32'h10);
        check(pinLevel[0], 1'b1);
        // forced compare: only the waveform state moves
        prep(8'h99, 8'h40);
        apb(1'b1, ADDR_WAVE, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h30);
        apb(1'b1, ADDR_FORCE, 32'h1);
        apb(1'b0, ADDR_WAVE, 32'h0);
        check(rdData, 32'h1);
        check({compareFlagA, counterValue}, 9'h040);
        apb(1'b1, ADDR_CTRL, 32'h23);
        apb(1'b1, ADDR_FORCE, 32'h1);
        apb(1'b0, ADDR_WAVE, 32'h0);
        check(rdData, 32'h1);
        repeat (20) @(posedge clk_sys);
        check(counterValue, 8'h40);
        // extreme compare values in fast PWM, seen at the load
        prep(8'h00, 8'hfe);
        // start low, or a state left over from the force case counts as a spike
        apb(1'b1, ADDR_WAVE, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h23);
        hi = 0;
        repeat (512) begin
            ticks(1);
            hi += int'(pinLevel[0]);
        end
        check(hi, 2);
        check(overflowFlag, 1'b1);
        apb(1'b1, ADDR_FLAGS, 32'h1);
        check(overflowFlag, 1'b0);
        for (int p = 0; p < 2; p++) begin
            prep(8'hff, 8'h00);
            apb(1'b1, ADDR_CTRL, 32'h23 | (p << 4));
            ticks(256);
            hi = 0;
            repeat (256) begin
                ticks(1);
                hi += int'(pinLevel[0]);
            end
            check(hi, 256 * (1 - p));
        end
        // unmapped place and a second reset
        apb(1'b0, 8'h20, 32'h0);
        check(errSeen, 1'b1);
        check(rdData, 32'h0);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        check({counterValue, overflowFlag, compareFlagA, compareFlagB}, 11'h0);
        check(pinOeN, 2'b11);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rdData, 32'h0);
        summarize();
    end
endmodule

`default_nettype wire
